// [rtl/gpc_defines.vh]
// Constants for the general-purpose pin control port
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH

// Port size and address-mask position
`define GPC_PIN_MAX        8
`define GPC_MASK_LSB       2
`define GPC_ADDR_W         10

// Command codes
`define GPC_OP_DIR_SET     4'h0
`define GPC_OP_DIR_GET     4'h1
`define GPC_OP_ITYPE_SET   4'h2
`define GPC_OP_ITYPE_GET   4'h3
`define GPC_OP_PAD_SET     4'h4
`define GPC_OP_PAD_GET     4'h5
`define GPC_OP_INT_EN      4'h6
`define GPC_OP_INT_DIS     4'h7
`define GPC_OP_INT_CLR     4'h8
`define GPC_OP_ADC_EN      4'h9
`define GPC_OP_ADC_DIS     4'ha
`define GPC_OP_DMA_EN      4'hb
`define GPC_OP_DMA_DIS     4'hc
`define GPC_OP_INT_STAT    4'hd

// Direction and control modes
`define GPC_DIR_IN         2'h0
`define GPC_DIR_OUT        2'h1
`define GPC_DIR_HW         2'h2

// Interrupt conditions
`define GPC_IT_FALL        3'h0
`define GPC_IT_RISE        3'h1
`define GPC_IT_BOTH        3'h2
`define GPC_IT_LOW         3'h3
`define GPC_IT_HIGH        3'h4

// Drive strength codes
`define GPC_STR_2MA        2'h0
`define GPC_STR_4MA        2'h1
`define GPC_STR_8MA        2'h2
`define GPC_STR_8MA_SC     2'h3

// Pad type codes
`define GPC_PT_STD         3'h0
`define GPC_PT_STD_WPU     3'h1
`define GPC_PT_STD_WPD     3'h2
`define GPC_PT_OD          3'h3
`define GPC_PT_OD_WPU      3'h4
`define GPC_PT_OD_WPD      3'h5
`define GPC_PT_ANALOG      3'h6

// Argument field positions
`define GPC_ARG_STR_LSB    0
`define GPC_ARG_PT_LSB     4

// Reset values
`define GPC_RST_BYTE       8'h00
`define GPC_RST_ITYPE      24'h000000
`define GPC_RST_STR        16'h0000

`endif

// [rtl/gpc_pin_detect.v]
// Pin synchroniser and per-pin interrupt condition detector
`timescale 1ns/1ps
`include "gpc_defines.vh"

module gpc_pin_detect #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire               sys_clk,
  input  wire               reset,
  // Pins and per-pin condition select
  input  wire [WIDTH-1:0]   pin_async,
  input  wire [3*WIDTH-1:0] itype_flat,
  // Results
  output wire [WIDTH-1:0]   pin_sync,
  output reg  [WIDTH-1:0]   evt
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  reg [WIDTH-1:0] prev_reg;
  reg [2:0]       prime_reg;
  integer         i;

  // Two-stage synchroniser, then a history stage for edges
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_reg  <= {WIDTH{1'b0}};
      sync_reg  <= {WIDTH{1'b0}};
      prev_reg  <= {WIDTH{1'b0}};
      prime_reg <= 3'h0;
    end
    else
    begin
      meta_reg  <= pin_async;
      sync_reg  <= meta_reg;
      prev_reg  <= sync_reg;
      prime_reg <= {prime_reg[1:0], 1'b1};
    end
  end

  assign pin_sync = sync_reg;

  // Condition match per pin; edges wait until the history stage holds a real
  // pin sample, so a pin idling high gives no false edge after reset
  always @*
  begin
    evt = {WIDTH{1'b0}};
    for (i = 0; i < WIDTH; i = i + 1)
    begin
      case (itype_flat[3*i +: 3])
        `GPC_IT_FALL: evt[i] = prime_reg[2] & prev_reg[i] & ~sync_reg[i];
        `GPC_IT_RISE: evt[i] = prime_reg[2] & ~prev_reg[i] & sync_reg[i];
        `GPC_IT_BOTH: evt[i] = prime_reg[2] & (prev_reg[i] ^ sync_reg[i]);
        `GPC_IT_LOW:  evt[i] = ~sync_reg[i];
        `GPC_IT_HIGH: evt[i] = sync_reg[i];
        default:      evt[i] = 1'b0;
      endcase
    end
  end

endmodule // gpc_pin_detect

// [rtl/gpc_port.v]
// General-purpose eight-pin port with masked access and pin events
`timescale 1ns/1ps
`include "gpc_defines.vh"

module gpc_port #(
  parameter PIN_COUNT      = 8,
  parameter PERIPH_PRESENT = 8'hff
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset,
  // Command port
  input  wire        cmd_valid,
  input  wire [3:0]  cmd_op,
  input  wire [7:0]  pin_select_mask,
  input  wire [2:0]  pin_index,
  input  wire [7:0]  cmd_arg,
  output reg         cmd_done,
  output reg  [7:0]  cmd_rdata,
  // Masked data access
  input  wire        data_wr,
  input  wire        data_rd,
  input  wire [9:0]  data_addr,
  input  wire [7:0]  data_wdata,
  output reg         data_rvalid,
  output reg  [7:0]  data_rdata,
  // Pad side
  input  wire [7:0]  pin_in,
  output reg  [7:0]  pin_out,
  output reg  [7:0]  pin_oe,
  output reg  [7:0]  pull_up_en,
  output reg  [7:0]  pull_dn_en,
  output reg  [15:0] drive_sel,
  output reg  [7:0]  slew_en,
  output reg  [7:0]  digital_en,
  // Peripheral side
  input  wire [7:0]  periph_out,
  input  wire [7:0]  periph_oe,
  output reg  [7:0]  periph_in,
  output reg  [7:0]  periph_sel,
  // Events
  output reg  [7:0]  int_raw,
  output reg         gpio_irq,
  output reg         adc_trigger,
  output reg         dma_trigger
);

  localparam [7:0] PRESENT = (PIN_COUNT >= 8) ? 8'hff : ((8'h01 << PIN_COUNT) - 8'h01);

  // Field read of a packed per-pin vector
  function [2:0] field3;
    input [23:0] vec;
    input [2:0]  idx;
    begin
      field3 = vec[idx*3 +: 3];
    end
  endfunction

  // Merge selected bits of a new value into a byte
  function [7:0] merge8;
    input [7:0] old;
    input [7:0] val;
    input [7:0] sel;
    begin
      merge8 = (old & ~sel) | (val & sel);
    end
  endfunction

  // Configuration state
  reg  [7:0]  data_reg;
  reg  [7:0]  dir_out_reg;
  reg  [7:0]  dir_hw_reg;
  reg  [23:0] itype_reg;
  reg  [15:0] str_reg;
  reg  [7:0]  od_reg;
  reg  [7:0]  wpu_reg;
  reg  [7:0]  wpd_reg;
  reg  [7:0]  ana_reg;
  reg  [7:0]  int_en_reg;
  reg  [7:0]  int_st_reg;
  reg  [7:0]  adc_en_reg;
  reg  [7:0]  dma_en_reg;

  wire [7:0]  pin_sync;
  wire [7:0]  evt;
  wire [7:0]  sel = pin_select_mask & PRESENT;
  wire [7:0]  amask = data_addr[`GPC_MASK_LSB +: 8] & PRESENT;
  wire [7:0]  live_evt = evt & ~dir_out_reg & PRESENT;
  wire [1:0]  str_arg = cmd_arg[`GPC_ARG_STR_LSB +: 2];
  wire [2:0]  pt_arg = cmd_arg[`GPC_ARG_PT_LSB +: 3];
  wire        pt_od = (pt_arg == `GPC_PT_OD) | (pt_arg == `GPC_PT_OD_WPU) | (pt_arg == `GPC_PT_OD_WPD);
  wire        pt_wpu = (pt_arg == `GPC_PT_STD_WPU) | (pt_arg == `GPC_PT_OD_WPU);
  wire        pt_wpd = (pt_arg == `GPC_PT_STD_WPD) | (pt_arg == `GPC_PT_OD_WPD);
  wire        pt_ana = (pt_arg == `GPC_PT_ANALOG);
  wire        is_cmd_op_set = cmd_valid;
  integer     i;
  integer     j;

  // Input synchroniser and condition detection
  gpc_pin_detect #(
    .WIDTH      (8)
  ) u_detect (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .pin_async  (pin_in),
    .itype_flat (itype_reg),
    .pin_sync   (pin_sync),
    .evt        (evt)
  );

  // Masked data store, written by address-mask access
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      data_reg <= `GPC_RST_BYTE;
    else if (data_wr)
      data_reg <= merge8(data_reg, data_wdata, amask);
  end

  // Direction, pad and trigger configuration by mask
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      dir_out_reg <= `GPC_RST_BYTE;
      dir_hw_reg  <= `GPC_RST_BYTE;
      itype_reg   <= `GPC_RST_ITYPE;
      str_reg     <= `GPC_RST_STR;
      od_reg      <= `GPC_RST_BYTE;
      wpu_reg     <= `GPC_RST_BYTE;
      wpd_reg     <= `GPC_RST_BYTE;
      ana_reg     <= `GPC_RST_BYTE;
      int_en_reg  <= `GPC_RST_BYTE;
      adc_en_reg  <= `GPC_RST_BYTE;
      dma_en_reg  <= `GPC_RST_BYTE;
    end
    else if (is_cmd_op_set)
    begin
      case (cmd_op)
        `GPC_OP_DIR_SET:
        begin
          // Unknown mode codes fall back to input
          dir_out_reg <= merge8(dir_out_reg, {8{cmd_arg[1:0] == `GPC_DIR_OUT}}, sel);
          dir_hw_reg  <= merge8(dir_hw_reg, {8{cmd_arg[1:0] == `GPC_DIR_HW}}, sel);
        end
        `GPC_OP_ITYPE_SET:
        begin
          for (j = 0; j < 8; j = j + 1)
          begin
            if (sel[j] && cmd_arg[2:0] <= `GPC_IT_HIGH)
              itype_reg[j*3 +: 3] <= cmd_arg[2:0];
          end
        end
        `GPC_OP_PAD_SET:
        begin
          for (j = 0; j < 8; j = j + 1)
          begin
            if (sel[j])
              str_reg[j*2 +: 2] <= str_arg;
          end
          od_reg  <= merge8(od_reg, {8{pt_od}}, sel);
          wpu_reg <= merge8(wpu_reg, {8{pt_wpu}}, sel);
          wpd_reg <= merge8(wpd_reg, {8{pt_wpd}}, sel);
          ana_reg <= merge8(ana_reg, {8{pt_ana}}, sel);
        end
        `GPC_OP_INT_EN:  int_en_reg <= int_en_reg | sel;
        `GPC_OP_INT_DIS: int_en_reg <= int_en_reg & ~sel;
        `GPC_OP_ADC_EN:  adc_en_reg <= adc_en_reg | sel;
        `GPC_OP_ADC_DIS: adc_en_reg <= adc_en_reg & ~sel;
        `GPC_OP_DMA_EN:  dma_en_reg <= dma_en_reg | sel;
        `GPC_OP_DMA_DIS: dma_en_reg <= dma_en_reg & ~sel;
        default:         int_en_reg <= int_en_reg;
      endcase
    end
  end

  // Sticky pending flags; a new event beats a clear in the same cycle
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      int_st_reg <= `GPC_RST_BYTE;
    else if (cmd_valid && cmd_op == `GPC_OP_INT_CLR)
      int_st_reg <= (int_st_reg & ~sel) | live_evt;
    else
      int_st_reg <= int_st_reg | live_evt;
  end

  // Command answers: single-pin getters and status read
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cmd_done  <= 1'b0;
      cmd_rdata <= 8'h00;
    end
    else
    begin
      cmd_done  <= cmd_valid;
      cmd_rdata <= 8'h00;
      if (cmd_valid)
      begin
        case (cmd_op)
          `GPC_OP_DIR_GET:
            cmd_rdata <= dir_hw_reg[pin_index] ? {6'h00, `GPC_DIR_HW} :
                         dir_out_reg[pin_index] ? {6'h00, `GPC_DIR_OUT} :
                         {6'h00, `GPC_DIR_IN};
          `GPC_OP_ITYPE_GET:
            cmd_rdata <= {5'h00, field3(itype_reg, pin_index)};
          `GPC_OP_PAD_GET:
            cmd_rdata <= {1'b0,
                          ana_reg[pin_index] ? `GPC_PT_ANALOG :
                          od_reg[pin_index] ? (wpu_reg[pin_index] ? `GPC_PT_OD_WPU :
                                               wpd_reg[pin_index] ? `GPC_PT_OD_WPD : `GPC_PT_OD) :
                          wpu_reg[pin_index] ? `GPC_PT_STD_WPU :
                          wpd_reg[pin_index] ? `GPC_PT_STD_WPD : `GPC_PT_STD,
                          2'h0, str_reg[pin_index*2 +: 2]};
          `GPC_OP_INT_STAT:
            cmd_rdata <= cmd_arg[0] ? (int_st_reg & int_en_reg) : int_st_reg;
          default:
            cmd_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Masked data read: outputs read back stored data, others the pin
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      data_rvalid <= 1'b0;
      data_rdata  <= 8'h00;
    end
    else
    begin
      data_rvalid <= data_rd;
      if (data_rd)
        data_rdata <= ((data_reg & dir_out_reg) | (pin_sync & ~dir_out_reg)) & amask;
    end
  end

  // Pad drive: data only in output mode, peripheral in hardware mode
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_out    <= 8'h00;
      pin_oe     <= 8'h00;
      pull_up_en <= 8'h00;
      pull_dn_en <= 8'h00;
      drive_sel  <= 16'h0000;
      slew_en    <= 8'h00;
      digital_en <= 8'h00;
      periph_in  <= 8'h00;
      periph_sel <= 8'h00;
    end
    else
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        // Open drain only ever pulls low; a high level releases the pad
        if (!PRESENT[i] || ana_reg[i])
        begin
          pin_out[i] <= 1'b0;
          pin_oe[i]  <= 1'b0;
        end
        else if (dir_hw_reg[i])
        begin
          pin_out[i] <= od_reg[i] ? 1'b0 : periph_out[i];
          pin_oe[i]  <= PERIPH_PRESENT[i] & periph_oe[i] &
                        (od_reg[i] ? ~periph_out[i] : 1'b1);
        end
        else if (dir_out_reg[i])
        begin
          pin_out[i] <= od_reg[i] ? 1'b0 : data_reg[i];
          pin_oe[i]  <= od_reg[i] ? ~data_reg[i] : 1'b1;
        end
        else
        begin
          pin_out[i] <= 1'b0;
          pin_oe[i]  <= 1'b0;
        end
        // Strength code 3 is 8 mA with slew control
        drive_sel[i*2 +: 2] <= (str_reg[i*2 +: 2] == `GPC_STR_8MA_SC) ? `GPC_STR_8MA : str_reg[i*2 +: 2];
        slew_en[i]          <= (str_reg[i*2 +: 2] == `GPC_STR_8MA_SC);
      end
      pull_up_en <= wpu_reg & PRESENT;
      pull_dn_en <= wpd_reg & PRESENT;
      digital_en <= ~ana_reg & PRESENT;
      periph_in  <= pin_sync & dir_hw_reg & PERIPH_PRESENT;
      periph_sel <= dir_hw_reg & PRESENT;
    end
  end

  // Interrupt line and conversion/transfer triggers
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      int_raw     <= 8'h00;
      gpio_irq    <= 1'b0;
      adc_trigger <= 1'b0;
      dma_trigger <= 1'b0;
    end
    else
    begin
      int_raw     <= int_st_reg;
      gpio_irq    <= |(int_st_reg & int_en_reg);
      adc_trigger <= |(live_evt & adc_en_reg);
      dma_trigger <= |(live_evt & dma_en_reg);
    end
  end

endmodule // gpc_port

// [test/gpc_port_assertions.sv]
// Concurrent checks on the ports of the pin control port
`timescale 1ns/1ps
`include "gpc_defines.vh"

module gpc_port_assertions (
  // Clock and reset
  input wire        sys_clk,
  input wire        reset,
  // Command and data access
  input wire        cmd_valid,
  input wire        cmd_done,
  input wire [7:0]  cmd_rdata,
  input wire        data_rd,
  input wire [9:0]  data_addr,
  input wire        data_rvalid,
  input wire [7:0]  data_rdata,
  // Pad and event outputs
  input wire [7:0]  pin_oe,
  input wire [7:0]  pull_up_en,
  input wire [7:0]  pull_dn_en,
  input wire [15:0] drive_sel,
  input wire [7:0]  slew_en,
  input wire [7:0]  digital_en,
  input wire [7:0]  int_raw,
  input wire        gpio_irq,
  input wire        adc_trigger
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Pins whose drive setting is the 8 mA code
  logic [7:0] at8;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      at8[i] = (drive_sel[2*i +: 2] == `GPC_STR_8MA);
  end

  // Request and answer steps of the two handshakes
  sequence s_cmd_taken; cmd_valid; endsequence
  sequence s_cmd_answer; cmd_done; endsequence
  sequence s_rd_taken; data_rd; endsequence
  sequence s_rd_answer; data_rvalid; endsequence

  a_cmd_answer: assert property (s_cmd_taken |=> s_cmd_answer) else $error("command not answered");
  a_cmd_quiet: assert property (!cmd_valid |=> !cmd_done) else $error("stray command done");
  a_rd_answer: assert property (s_rd_taken |=> s_rd_answer) else $error("read not answered");
  a_rd_quiet: assert property (!data_rd |=> !data_rvalid) else $error("stray read valid");
  a_rdata_idle: assert property (!cmd_done |-> cmd_rdata == 8'h00) else $error("command data outside done");
  a_rdata_hold: assert property (!data_rvalid |-> $stable(data_rdata)) else $error("read data moved");
  a_rdata_mask: assert property (data_rvalid |-> (data_rdata & ~8'($past(data_addr) >> 2)) == 8'h00)
    else $error("unselected pin in read data");
  a_pull_excl: assert property ((pull_up_en & pull_dn_en) == 8'h00) else $error("both pulls on");
  a_slew_8ma: assert property ((slew_en & ~at8) == 8'h00) else $error("slew without 8 mA");
  a_analog_nodrive: assert property ((pin_oe & ~digital_en) == 8'h00) else $error("analog pin driven");
  // Line and flags leave the same pending state on the same edge
  a_irq_needs_flag: assert property (gpio_irq |-> int_raw != 8'h00) else $error("irq without flag");
  c_adc_trigger: cover property (adc_trigger);
endmodule // gpc_port_assertions

// [test/gpc_pin_model.sv]
// Pin-side model: pad wire levels and a looped-back peripheral
`timescale 1ns/1ps

module gpc_pin_model (
  // Pad side of the port
  input  wire  [7:0] pin_out,
  input  wire  [7:0] pin_oe,
  input  wire  [7:0] pull_up_en,
  input  wire  [7:0] pull_dn_en,
  input  wire  [7:0] ext_level,
  output logic [7:0] pin_in,
  // Peripheral side of the port
  input  wire  [7:0] periph_in,
  output logic [7:0] periph_out,
  output logic [7:0] periph_oe
);
  // Port drive wins, then a weak pull, else the outside driver
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : pull_up_en[i] ? 1'b1 : pull_dn_en[i] ? 1'b0 : ext_level[i];
  end
  // Peripheral always drives the inverse of what it receives
  assign periph_out = ~periph_in;
  assign periph_oe  = 8'hff;
endmodule // gpc_pin_model

// [test/tb_top.sv]
// Self-checking bench for the pin control port
`timescale 1ns/1ps
`include "gpc_defines.vh"

module tb_top;
  typedef struct packed { logic [7:0] wm, wd, rm, erd, eout; } gpc_row_t;
  // Driven inputs
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic       cmd_valid = 1'b0;
  logic [3:0] cmd_op = 4'h0;
  logic [7:0] pin_select_mask = 8'h00;
  logic [2:0] pin_index = 3'h0;
  logic [7:0] cmd_arg = 8'h00;
  logic       data_wr = 1'b0;
  logic       data_rd = 1'b0;
  logic [9:0] data_addr = 10'h000;
  logic [7:0] data_wdata = 8'h00;
  logic [7:0] ext_level = 8'h00;
  // Design outputs and bench state
  wire        cmd_done, data_rvalid, gpio_irq, adc_trigger, dma_trigger;
  wire [7:0]  cmd_rdata, data_rdata, pin_in, pin_out, pin_oe, pull_up_en, pull_dn_en;
  wire [7:0]  slew_en, digital_en, periph_out, periph_oe, periph_in, periph_sel, int_raw;
  wire [15:0] drive_sel;
  int         failures = 0;
  int         n_tests = 0;
  logic [7:0] rd;
  logic       saw_adc = 1'b0;
  logic       saw_dma = 1'b0;
  logic       saw_per = 1'b0;
  logic       ex;
  // Masked write, masked read, expected read and expected pins
  gpc_row_t rows [6] = '{{8'hff, 8'ha5, 8'hff, 8'ha5, 8'ha5}, {8'h0f, 8'h3c, 8'hff, 8'hac, 8'hac},
    {8'h09, 8'hff, 8'hff, 8'had, 8'had}, {8'hf0, 8'h00, 8'h3c, 8'h0c, 8'h0d},
    {8'h00, 8'hff, 8'hff, 8'h0d, 8'h0d}, {8'h00, 8'h00, 8'h00, 8'h00, 8'h0d}};

  always #2.5 sys_clk = ~sys_clk;

  gpc_port dut_u (.sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .pin_select_mask(pin_select_mask), .pin_index(pin_index), .cmd_arg(cmd_arg), .cmd_done(cmd_done),
    .cmd_rdata(cmd_rdata), .data_wr(data_wr), .data_rd(data_rd), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_rvalid(data_rvalid), .data_rdata(data_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
    .drive_sel(drive_sel), .slew_en(slew_en), .digital_en(digital_en), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in(periph_in), .periph_sel(periph_sel), .int_raw(int_raw),
    .gpio_irq(gpio_irq), .adc_trigger(adc_trigger), .dma_trigger(dma_trigger));

  gpc_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .ext_level(ext_level), .pin_in(pin_in), .periph_in(periph_in),
    .periph_out(periph_out), .periph_oe(periph_oe));

  // Remember that each trigger and periph_in[7] went high at least once
  always @(posedge sys_clk)
  begin
    if (adc_trigger === 1'b1) saw_adc <= 1'b1;
    if (dma_trigger === 1'b1) saw_dma <= 1'b1;
    if (periph_in[7] === 1'b1) saw_per <= 1'b1;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t mismatch: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge sys_clk) reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
  endtask

  // One command, answered exactly one edge later
  task automatic cmd(input logic [3:0] op, input logic [7:0] mask, input logic [2:0] idx, input logic [7:0] arg);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    pin_select_mask <= mask;
    pin_index <= idx;
    cmd_arg <= arg;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
    chk(cmd_done, 1'b1);
    rd = cmd_rdata;
  endtask

  // Masked data write and read; the mask rides on the address
  task automatic wr(input logic [7:0] mask, input logic [7:0] val);
    @(posedge sys_clk);
    data_wr <= 1'b1;
    data_addr <= {mask, 2'b00};
    data_wdata <= val;
    @(posedge sys_clk);
    data_wr <= 1'b0;
  endtask

  task automatic rdm(input logic [7:0] mask);
    @(posedge sys_clk);
    data_rd <= 1'b1;
    data_addr <= {mask, 2'b00};
    @(posedge sys_clk);
    data_rd <= 1'b0;
    #1;
    chk(data_rvalid, 1'b1);
    rd = data_rdata;
  endtask

  // Hang guard: a bounded wait that ends the run as a mismatch
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    results();
  end

  initial
  begin
    do_reset();
    cmd(`GPC_OP_DIR_SET, 8'hff, 3'h0, {6'h00, `GPC_DIR_OUT});
    for (int i = 0; i < 6; i++)
    begin
      wr(rows[i].wm, rows[i].wd);
      rdm(rows[i].rm);
      chk(rd, rows[i].erd);
      chk(pin_out, rows[i].eout);
    end
    cmd(4'hf, 8'hff, 3'h0, 8'hff);
    cyc(2);
    chk(pin_out, 8'h0d);
    // Second reset, then defaults
    do_reset();
    cyc(1);
    chk(pin_oe, 8'h00);
    chk(pull_up_en | pull_dn_en, 8'h00);
    chk(drive_sel, 16'h0000);
    chk(slew_en, 8'h00);
    chk(periph_sel, 8'h00);
    chk(digital_en, 8'hff);
    cmd(`GPC_OP_DIR_GET, 8'h00, 3'h5, 8'h00);
    chk(rd, {6'h00, `GPC_DIR_IN});
    cmd(`GPC_OP_PAD_GET, 8'h00, 3'h5, 8'h00);
    chk(rd, 8'h00);
    // Data written to inputs drives nothing until output mode
    wr(8'hff, 8'h55);
    cyc(2);
    chk(pin_oe, 8'h00);
    cmd(`GPC_OP_DIR_SET, 8'h0f, 3'h0, {6'h00, `GPC_DIR_OUT});
    cyc(2);
    chk(pin_oe, 8'h0f);
    chk(pin_out & 8'h0f, 8'h05);
    cmd(`GPC_OP_DIR_SET, 8'h80, 3'h0, {6'h00, `GPC_DIR_HW});
    cmd(`GPC_OP_DIR_GET, 8'h00, 3'h7, 8'h00);
    chk(rd, {6'h00, `GPC_DIR_HW});
    cyc(3);
    chk(periph_sel, 8'h80);
    chk(pin_oe[7], 1'b1);
    chk(periph_in & 8'h7f, 8'h00);
    cmd(`GPC_OP_DIR_SET, 8'h40, 3'h0, 8'h03);
    cmd(`GPC_OP_DIR_GET, 8'h00, 3'h6, 8'h00);
    chk(rd, {6'h00, `GPC_DIR_IN});
    // Every pad type and strength on pin 1, driven high
    wr(8'h02, 8'hff);
    for (int pt = 0; pt < 7; pt++)
    begin
      cmd(`GPC_OP_PAD_SET, 8'h02, 3'h0, {1'b0, 3'(pt), 2'b00, 2'(pt % 4)});
      cmd(`GPC_OP_PAD_GET, 8'h00, 3'h1, 8'h00);
      chk(rd, {1'b0, 3'(pt), 2'b00, 2'(pt % 4)});
      cyc(1);
      chk(drive_sel[3:2], (pt % 4 == 3) ? 2'h2 : 2'(pt % 4));
      chk(slew_en[1], pt % 4 == 3);
      chk(pull_up_en[1], pt == 1 || pt == 4);
      chk(pull_dn_en[1], pt == 2 || pt == 5);
      chk(digital_en[1], pt != 6);
      // Pin 1 holds a high: push-pull drives it, open drain releases it
      chk(pin_oe, {5'b10001, 1'b1, pt < 3, 1'b1});
    end
    // Every interrupt condition on input pin 4
    cmd(`GPC_OP_INT_EN, 8'h10, 3'h0, 8'h00);
    cmd(`GPC_OP_ADC_EN, 8'h10, 3'h0, 8'h00);
    cmd(`GPC_OP_DMA_EN, 8'h10, 3'h0, 8'h00);
    for (int t = 0; t < 5; t++)
    begin
      cmd(`GPC_OP_ITYPE_SET, 8'h10, 3'h0, 8'(t));
      cmd(`GPC_OP_ITYPE_GET, 8'h00, 3'h4, 8'h00);
      chk(rd, 8'(t));
      cmd(`GPC_OP_INT_CLR, 8'h10, 3'h0, 8'h00);
      cyc(2);
      chk(int_raw[4], t == 3);
      @(posedge sys_clk) ext_level[4] <= 1'b1;
      cyc(6);
      // A low-level flag set before the rise stays pending until cleared
      ex = (t == 1 || t == 2 || t == 3 || t == 4);
      chk(int_raw[4], ex);
      cmd(`GPC_OP_INT_CLR, 8'hef, 3'h0, 8'h00);
      cyc(1);
      chk(int_raw[4], ex);
      chk(gpio_irq, ex);
      cmd(`GPC_OP_INT_STAT, 8'h00, 3'h0, 8'h01);
      chk(rd, {3'b000, ex, 4'h0});
      cmd(`GPC_OP_INT_STAT, 8'h00, 3'h0, 8'h00);
      chk(rd[4], ex);
      cmd(`GPC_OP_INT_CLR, 8'h10, 3'h0, 8'h00);
      cyc(2);
      chk(int_raw[4], t == 4);
      @(posedge sys_clk) ext_level[4] <= 1'b0;
      cyc(6);
      // A high-level flag stays pending after the fall
      chk(int_raw[4], t != 1);
    end
    cmd(`GPC_OP_ADC_DIS, 8'h10, 3'h0, 8'h00);
    cmd(`GPC_OP_DMA_DIS, 8'h10, 3'h0, 8'h00);
    cmd(`GPC_OP_INT_DIS, 8'h10, 3'h0, 8'h00);
    cmd(`GPC_OP_INT_STAT, 8'h00, 3'h0, 8'h01);
    chk(rd, 8'h00);
    chk(saw_adc, 1'b1);
    chk(saw_dma, 1'b1);
    chk(saw_per, 1'b1);
    results();
  end
endmodule // tb_top

bind gpc_port gpc_port_assertions chk_u (.sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid),
  .cmd_done(cmd_done), .cmd_rdata(cmd_rdata), .data_rd(data_rd), .data_addr(data_addr),
  .data_rvalid(data_rvalid), .data_rdata(data_rdata), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
  .pull_dn_en(pull_dn_en), .drive_sel(drive_sel), .slew_en(slew_en), .digital_en(digital_en),
  .int_raw(int_raw), .gpio_irq(gpio_irq), .adc_trigger(adc_trigger));
